// *** hw/drive_seq_regs.vh ***
// Functional notes
// - brake input forces dc braking enabled
// - brake delay 0.0 to 5.0 seconds
// - brake force max 100 or 35 percent
// - terminal run: brake release resumes previous frequency
// - keypad run: brake release keeps output off
// - keypad run: coast for delay, then brake
// - motor select inputs pick sets two/three
// - motor set changes only while stopped
// - both selects asserted: second set wins
// - stage-2 input selects second ramp times
// - stage-2 input only when method is 00
// - coast input: output off, resume if running
// - restart origin: zero or present speed
// - restart wait before resume, zero skips
// - per-input polarity allows active low, except the reset terminal
// - fault rising edge: trip, code 12, alarm
// - outside fault trip latched until reset
// - guard: after fault trip need new run
// - guard: run at power-on trips code 13
// - reset of code 13 with run restarts
// - undervolt trip reset still checks guard
// - alarm drops within 30 ms of reset
`ifndef DRIVE_SEQ_REGS_VH
`define DRIVE_SEQ_REGS_VH
// register byte offsets
`define REG_CTRL 8'h00
`define REG_BRAKE 8'h04
`define REG_RATE1 8'h08
`define REG_RATE2 8'h0C
`define REG_RESTART 8'h10
`define REG_STATUS 8'h14
// control fields
`define CTRL_BRAKE_EN 0
`define CTRL_METHOD_LO 1
`define CTRL_ORIGIN 3
`define CTRL_POL_LO 8
// reset values
`define CTRL_RST 32'h0000_0000
`define BRAKE_RST 32'h0000_0000
`define RATE_RST 32'h0064_0064
`define RESTART_RST 8'h00
// limits, in tenths of a second and percent
`define BRAKE_DELAY_MAX 6'h32
`define FORCE_MAX_SMALL 7'h64
`define FORCE_MAX_LARGE 7'h23
// trip codes
`define CODE_NONE 8'h00
`define CODE_UNDERVOLT 8'h09
`define CODE_OUTSIDE 8'h0C
`define CODE_POWERUP 8'h0D
// timing
`define CLK_HZ 10000000
`define TENTH_MS 100
`define FILTER_US 1000
`define TENTH_CYCLES (`CLK_HZ / 1000 * `TENTH_MS)
`define FILTER_CYCLES (`CLK_HZ / 1000000 * `FILTER_US)
`endif

// *** hw/drive_input_function_sequencer.v ***
`timescale 1ns/1ps
`default_nettype none
`include "drive_seq_regs.vh"

// two-flop synchroniser plus stability filter for one terminal
module input_filter #(
  parameter integer STABLE = 16
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // raw and cleaned level
  input wire raw_i,
  output reg clean_o
);
  reg sync_a; // first stage, read only by sync_b
  reg sync_b; // second stage
  reg [19:0] cnt; // samples differing from clean_o

  // sync then require STABLE equal samples before switching
  always @(posedge clk_i) begin
    if (rst_i) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      cnt <= 20'h00000;
      clean_o <= 1'b0;
    end else begin
      sync_a <= raw_i;
      sync_b <= sync_a;
      if (sync_b == clean_o) begin
        cnt <= 20'h00000;
      end else if (cnt == STABLE[19:0] - 20'h00001) begin
        clean_o <= sync_b;
        cnt <= 20'h00000;
      end else begin
        cnt <= cnt + 20'h00001;
      end
    end
  end
endmodule // input_filter

module drive_input_function_sequencer #(
  parameter integer TENTH_CYCLES = `TENTH_CYCLES, // cycles per 0.1 s
  parameter integer FILTER_CYCLES = `FILTER_CYCLES, // terminal filter length
  parameter integer LARGE_MODEL = 0 // 1 limits brake force to 35 percent
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // control terminals, raw
  input wire ext_dc_brake_in_i,
  input wire alt_motor2_select_i,
  input wire alt_motor3_select_i,
  input wire accel_stage2_select_i,
  input wire coast_stop_in_i,
  input wire outside_fault_in_i,
  input wire powerup_run_guard_i,
  input wire forward_run_in_i,
  input wire reverse_run_in_i,
  input wire reset_terminal_i,
  // keypad and supply events
  input wire keypad_run_i,
  input wire keypad_reset_i,
  input wire undervolt_i,
  // drive outputs
  output reg output_on_o,
  output reg dc_brake_o,
  output reg brake_enable_o,
  output reg [6:0] brake_force_o,
  output reg [1:0] motor_set_o,
  output reg [15:0] accel_time_o,
  output reg [15:0] decel_time_o,
  output reg restart_from_speed_o,
  output reg resume_prev_o,
  output reg alarm_o,
  output reg [7:0] trip_code_o
);
  // one-hot states
  localparam [5:0] ST_STOP = 6'h01;
  localparam [5:0] ST_RUN = 6'h02;
  localparam [5:0] ST_DELAY = 6'h04;
  localparam [5:0] ST_BRAKE = 6'h08;
  localparam [5:0] ST_COAST = 6'h10;
  localparam [5:0] ST_TRIP = 6'h20;
  localparam [6:0] FORCE_MAX = (LARGE_MODEL != 0) ? `FORCE_MAX_LARGE : `FORCE_MAX_SMALL;

  // software registers
  reg [31:0] ctrl; // enable, method, origin, polarity
  reg [31:0] brake; // delay [5:0], force [14:8]
  reg [31:0] rate1; // accel1 low, decel1 high
  reg [31:0] rate2; // accel2 low, decel2 high
  reg [7:0] restart_wait; // tenths of a second

  // terminal conditioning
  wire [9:0] raw = {reset_terminal_i, reverse_run_in_i, forward_run_in_i, powerup_run_guard_i,
                    outside_fault_in_i, coast_stop_in_i, accel_stage2_select_i,
                    alt_motor3_select_i, alt_motor2_select_i, ext_dc_brake_in_i};
  // reset terminal is normally open only, so bit 9 never inverts
  wire [9:0] pol = {1'b0, ctrl[`CTRL_POL_LO+8:`CTRL_POL_LO]};
  wire [9:0] clean; // filtered, active-high levels

  genvar gi;
  generate
    for (gi = 0; gi < 10; gi = gi + 1) begin : g_filt
      input_filter #(.STABLE(FILTER_CYCLES)) u_filt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .raw_i(raw[gi] ^ pol[gi]),
        .clean_o(clean[gi])
      );
    end
  endgenerate

  wire brake_in = clean[0];
  wire motor2_in = clean[1];
  wire motor3_in = clean[2];
  wire stage2 = clean[3];
  wire coast_in = clean[4];
  wire fault = clean[5];
  wire guard = clean[6];
  wire term_run = clean[7] | clean[8];
  wire reset_in = clean[9];
  wire run_cmd = term_run | keypad_run_i;

  // sequencer state
  reg [5:0] state;
  reg fault_d; // previous fault level
  reg reset_in_d; // previous reset level
  reg kp_rst_d; // previous keypad reset
  reg run_d; // previous run request
  reg need_edge; // blocks restart until a new run edge
  reg pu_check; // powerup guard check pending
  reg [19:0] settle; // wait for filters after power-on
  reg [19:0] presc; // 0.1 s prescaler
  reg [7:0] tenths; // elapsed tenths in a wait

  wire fault_rise = fault & ~fault_d;
  wire rst_cmd = (reset_in & ~reset_in_d) | (keypad_reset_i & ~kp_rst_d);
  wire run_rise = run_cmd & ~run_d;
  wire settled = (settle == 20'h00000);
  wire tick = (presc == TENTH_CYCLES[19:0] - 20'h00001);
  wire [7:0] delay_lim = {2'b00, brake[5:0]};
  wire delay_done = (delay_lim == 8'h00) || (tick && tenths == delay_lim - 8'h01);
  wire wait_done = (restart_wait == 8'h00) || (tick && tenths == restart_wait - 8'h01);
  wire use2 = stage2 && (ctrl[`CTRL_METHOD_LO+1:`CTRL_METHOD_LO] == 2'b00);
  wire [7:0] status = {2'b00, state};

  // wishbone access: ack one cycle after the strobe, unmapped reads zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl <= `CTRL_RST;
      brake <= `BRAKE_RST;
      rate1 <= `RATE_RST;
      rate2 <= `RATE_RST;
      restart_wait <= `RESTART_RST;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= 32'h0000_0000;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        if (wb_adr_i == `REG_CTRL) begin
          wb_dat_o <= ctrl;
          if (wb_we_i && wb_sel_i[0]) begin
            ctrl[7:0] <= wb_dat_i[7:0] & 8'h0F;
          end
          if (wb_we_i && wb_sel_i[1]) begin
            ctrl[15:8] <= wb_dat_i[15:8];
          end
          if (wb_we_i && wb_sel_i[2]) begin
            ctrl[16] <= wb_dat_i[16];
          end
        end else if (wb_adr_i == `REG_BRAKE) begin
          wb_dat_o <= brake;
          // out-of-range values clamp to the limit
          if (wb_we_i && wb_sel_i[0]) begin
            brake[5:0] <= (wb_dat_i[5:0] > `BRAKE_DELAY_MAX) ? `BRAKE_DELAY_MAX : wb_dat_i[5:0];
          end
          if (wb_we_i && wb_sel_i[1]) begin
            brake[14:8] <= (wb_dat_i[14:8] > FORCE_MAX) ? FORCE_MAX : wb_dat_i[14:8];
          end
        end else if (wb_adr_i == `REG_RATE1) begin
          wb_dat_o <= rate1;
          if (wb_we_i && wb_sel_i[0]) rate1[7:0] <= wb_dat_i[7:0];
          if (wb_we_i && wb_sel_i[1]) rate1[15:8] <= wb_dat_i[15:8];
          if (wb_we_i && wb_sel_i[2]) rate1[23:16] <= wb_dat_i[23:16];
          if (wb_we_i && wb_sel_i[3]) rate1[31:24] <= wb_dat_i[31:24];
        end else if (wb_adr_i == `REG_RATE2) begin
          wb_dat_o <= rate2;
          if (wb_we_i && wb_sel_i[0]) rate2[7:0] <= wb_dat_i[7:0];
          if (wb_we_i && wb_sel_i[1]) rate2[15:8] <= wb_dat_i[15:8];
          if (wb_we_i && wb_sel_i[2]) rate2[23:16] <= wb_dat_i[23:16];
          if (wb_we_i && wb_sel_i[3]) rate2[31:24] <= wb_dat_i[31:24];
        end else if (wb_adr_i == `REG_RESTART) begin
          wb_dat_o <= {24'h000000, restart_wait};
          if (wb_we_i && wb_sel_i[0]) restart_wait <= wb_dat_i[7:0];
        end else if (wb_adr_i == `REG_STATUS) begin
          // read only: state, trip code, motor set, alarm
          wb_dat_o <= {13'h0000, alarm_o, motor_set_o, trip_code_o, status};
        end
      end
    end
  end

  // output selection that follows terminals and registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      brake_enable_o <= 1'b0;
      brake_force_o <= 7'h00;
      accel_time_o <= 16'h0000;
      decel_time_o <= 16'h0000;
      motor_set_o <= 2'b00;
    end else begin
      brake_enable_o <= ctrl[`CTRL_BRAKE_EN] | brake_in;
      brake_force_o <= brake[14:8];
      // switches mid-ramp, since the ramp generator reads this every cycle
      accel_time_o <= use2 ? rate2[15:0] : rate1[15:0];
      decel_time_o <= use2 ? rate2[31:16] : rate1[31:16];
      if (state == ST_STOP) begin
        if (motor2_in) begin
          motor_set_o <= 2'b01;
        end else if (motor3_in) begin
          motor_set_o <= 2'b10;
        end else begin
          motor_set_o <= 2'b00;
        end
      end
    end
  end

  // run, stop and trip sequencer
  always @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_STOP;
      fault_d <= 1'b0;
      reset_in_d <= 1'b0;
      kp_rst_d <= 1'b0;
      run_d <= 1'b0;
      need_edge <= 1'b0;
      pu_check <= 1'b1;
      settle <= 20'hFFFFF;
      presc <= 20'h00000;
      tenths <= 8'h00;
      output_on_o <= 1'b0;
      dc_brake_o <= 1'b0;
      restart_from_speed_o <= 1'b0;
      resume_prev_o <= 1'b0;
      alarm_o <= 1'b0;
      trip_code_o <= `CODE_NONE;
    end else begin
      fault_d <= fault;
      reset_in_d <= reset_in;
      kp_rst_d <= keypad_reset_i;
      run_d <= run_cmd;
      resume_prev_o <= 1'b0;
      // settle covers the filter and synchroniser delay after power-on
      if (settle > 20'h00000 && settle > FILTER_CYCLES[19:0] + 20'h00004) begin
        settle <= FILTER_CYCLES[19:0] + 20'h00004;
      end else if (!settled) begin
        settle <= settle - 20'h00001;
      end
      if (run_rise) begin
        need_edge <= 1'b0;
      end
      // wait timer runs only in the timed states
      if (state == ST_DELAY || state == ST_COAST) begin
        presc <= tick ? 20'h00000 : presc + 20'h00001;
        if (tick) tenths <= tenths + 8'h01;
      end else begin
        presc <= 20'h00000;
        tenths <= 8'h00;
      end
      if (fault_rise && state != ST_TRIP) begin
        // edge, not level, so a held fault does not retrip after reset
        state <= ST_TRIP;
        trip_code_o <= `CODE_OUTSIDE;
        alarm_o <= 1'b1;
        output_on_o <= 1'b0;
        dc_brake_o <= 1'b0;
      end else if (undervolt_i && state != ST_TRIP) begin
        state <= ST_TRIP;
        trip_code_o <= `CODE_UNDERVOLT;
        alarm_o <= 1'b1;
        output_on_o <= 1'b0;
        dc_brake_o <= 1'b0;
      end else begin
        case (state)
          ST_STOP: begin
            output_on_o <= 1'b0;
            dc_brake_o <= 1'b0;
            if (settled && pu_check) begin
              pu_check <= 1'b0;
              if (guard && run_cmd) begin
                state <= ST_TRIP;
                trip_code_o <= `CODE_POWERUP;
                alarm_o <= 1'b1;
              end
            end else if (settled && run_cmd && !need_edge && !coast_in && !run_rise) begin
              state <= ST_RUN;
              output_on_o <= 1'b1;
              restart_from_speed_o <= 1'b0;
            end
          end
          ST_RUN: begin
            if (!run_cmd) begin
              state <= ST_STOP;
              output_on_o <= 1'b0;
            end else if (coast_in) begin
              state <= ST_COAST;
              output_on_o <= 1'b0;
            end else if (brake_in && term_run) begin
              state <= ST_BRAKE;
              output_on_o <= 1'b0;
              dc_brake_o <= 1'b1;
            end else if (brake_in) begin
              state <= ST_DELAY;
              output_on_o <= 1'b0;
            end
          end
          ST_DELAY: begin
            // keypad run: motor coasts while the brake delay elapses
            if (!brake_in) begin
              state <= ST_STOP;
              need_edge <= ~run_rise;
            end else if (delay_done) begin
              state <= ST_BRAKE;
              dc_brake_o <= 1'b1;
            end
          end
          ST_BRAKE: begin
            if (!brake_in && term_run) begin
              state <= ST_RUN;
              dc_brake_o <= 1'b0;
              output_on_o <= 1'b1;
              resume_prev_o <= 1'b1;
            end else if (!brake_in) begin
              state <= ST_STOP;
              dc_brake_o <= 1'b0;
              need_edge <= ~run_rise;
            end
          end
          ST_COAST: begin
            // timer counts from release only; held input keeps it at zero
            if (coast_in) begin
              presc <= 20'h00000;
              tenths <= 8'h00;
            end else if (!run_cmd) begin
              state <= ST_STOP;
            end else if (wait_done) begin
              state <= ST_RUN;
              output_on_o <= 1'b1;
              restart_from_speed_o <= ctrl[`CTRL_ORIGIN];
            end
          end
          ST_TRIP: begin
            output_on_o <= 1'b0;
            dc_brake_o <= 1'b0;
            if (rst_cmd) begin
              // alarm drops on the filtered reset onset, far inside 30 ms
              alarm_o <= 1'b0;
              trip_code_o <= `CODE_NONE;
              if (trip_code_o == `CODE_POWERUP && run_cmd) begin
                state <= ST_RUN;
                output_on_o <= 1'b1;
              end else begin
                state <= ST_STOP;
                need_edge <= guard && (trip_code_o == `CODE_OUTSIDE) && !run_rise;
                pu_check <= (trip_code_o == `CODE_UNDERVOLT);
              end
            end else if (trip_code_o == `CODE_POWERUP && !run_cmd) begin
              state <= ST_STOP;
              alarm_o <= 1'b0;
              trip_code_o <= `CODE_NONE;
            end
          end
          default: begin
            state <= ST_STOP;
          end
        endcase
      end
    end
  end
endmodule // drive_input_function_sequencer
`default_nettype wire

// *** dv/drive_seq_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module drive_seq_checker #(
  parameter integer FILTER_CYCLES = 4,
  parameter integer LARGE_MODEL = 0
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // terminals
  input wire outside_fault_in_i,
  input wire reset_terminal_i,
  input wire keypad_reset_i,
  // drive outputs
  input wire output_on_o,
  input wire dc_brake_o,
  input wire [6:0] brake_force_o,
  input wire [1:0] motor_set_o,
  input wire resume_prev_o,
  input wire alarm_o,
  input wire [7:0] trip_code_o
);
  // filter delay plus margin
  localparam int REACT = FILTER_CYCLES + 8;
  localparam logic [6:0] FMAX = (LARGE_MODEL != 0) ? 7'h23 : 7'h64;
  // cycles since the last reset request
  logic [5:0] quiet;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // saturating, so a long trip still counts as quiet
  always @(posedge clk_i) begin
    if (rst_i || reset_terminal_i || keypad_reset_i) begin
      quiet <= 6'h00;
    end else if (quiet != 6'h3F) begin
      quiet <= quiet + 6'h01;
    end
  end
  property p_ack_one;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack not one cycle after request");
  property p_dat_idle;
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_trip_off;
    alarm_o |-> !output_on_o && !dc_brake_o;
  endproperty
  a_trip_off: assert property (p_trip_off) else $error("output active while tripped");
  property p_alarm_code;
    alarm_o |-> trip_code_o inside {8'h09, 8'h0C, 8'h0D};
  endproperty
  a_alarm_code: assert property (p_alarm_code) else $error("alarm without trip code");
  property p_fault_trip;
    $rose(outside_fault_in_i) && !alarm_o && quiet > 6'h14 |-> ##[1:REACT] (alarm_o && trip_code_o == 8'h0C);
  endproperty
  a_fault_trip: assert property (p_fault_trip) else $error("fault edge did not trip");
  property p_trip_latch;
    alarm_o && trip_code_o == 8'h0C && quiet > 6'h14 && !keypad_reset_i |=> alarm_o;
  endproperty
  a_trip_latch: assert property (p_trip_latch) else $error("fault trip dropped alone");
  property p_reset_clear;
    $rose(reset_terminal_i) |-> ##[1:REACT] !alarm_o;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("alarm not cleared by reset");
  property p_set_hold;
    output_on_o && $past(output_on_o) |-> $stable(motor_set_o);
  endproperty
  a_set_hold: assert property (p_set_hold) else $error("motor set changed while running");
  property p_force_max;
    brake_force_o <= FMAX;
  endproperty
  a_force_max: assert property (p_force_max) else $error("brake force above limit");
  property p_resume;
    resume_prev_o |-> output_on_o ##1 !resume_prev_o;
  endproperty
  a_resume: assert property (p_resume) else $error("resume pulse malformed");
  c_outside: cover property (alarm_o && trip_code_o == 8'h0C);
  c_guard: cover property (alarm_o && trip_code_o == 8'h0D);
  c_resume: cover property (resume_prev_o);
  c_brake: cover property (dc_brake_o);
endmodule // drive_seq_checker
bind drive_input_function_sequencer drive_seq_checker #(
  .FILTER_CYCLES(FILTER_CYCLES),
  .LARGE_MODEL(LARGE_MODEL)
) drive_seq_checker_inst (.*);
`default_nettype wire

// *** dv/term_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// field switches: contacts per function, plus a reset button
module term_model #(
  parameter integer HOLD = 8
) (
  // clock
  input wire logic clk_i,
  // wanted logical levels and wiring polarity
  input wire logic [8:0] want_i,
  input wire logic [8:0] pol_i,
  input wire logic reset_req_i,
  // terminal lines
  output logic [8:0] line_o,
  output logic reset_terminal_o
);
  logic [7:0] hold_cnt; // remaining press time
  logic req_q; // request edge finder
  initial begin
    line_o = 9'h000;
    reset_terminal_o = 1'b0;
    hold_cnt = 8'h00;
    req_q = 1'b0;
  end
  // contacts move once per clock; normally closed ones read inverted
  always @(posedge clk_i) begin
    line_o <= want_i ^ pol_i;
    req_q <= reset_req_i;
    if (reset_req_i && !req_q) begin
      hold_cnt <= 8'(HOLD);
    end else if (hold_cnt != 8'h00) begin
      hold_cnt <= hold_cnt - 8'h01;
    end
    // short presses would be lost in the filter
    reset_terminal_o <= (hold_cnt != 8'h00);
  end
endmodule // term_model
`default_nettype wire

// *** dv/drive_input_function_sequencer_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "drive_seq_regs.vh"
module drive_input_function_sequencer_tb;
  // clock, reset and bus
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  // terminals and keypad
  logic ext_dc_brake_in_i, alt_motor2_select_i, alt_motor3_select_i, accel_stage2_select_i;
  logic coast_stop_in_i, outside_fault_in_i, powerup_run_guard_i, forward_run_in_i;
  logic reverse_run_in_i, reset_terminal_i, keypad_run_i, keypad_reset_i, undervolt_i;
  // drive outputs
  logic output_on_o, dc_brake_o, brake_enable_o, restart_from_speed_o, resume_prev_o, alarm_o;
  logic [6:0] brake_force_o;
  logic [1:0] motor_set_o;
  logic [15:0] accel_time_o, decel_time_o;
  logic [7:0] trip_code_o;
  // partner controls
  logic [8:0] want, pol, line;
  logic reset_req;
  int fails, tests_run, n;
  // terminal positions, polarity field order
  localparam int BRK = 0, SET2 = 1, SEL3 = 2, STG2 = 3, CST = 4, FLT = 5, GRD = 6, FWD = 7;
  // probe positions
  localparam int ON = 0, DC = 1, ALM = 2, RES = 3;
  assign {reverse_run_in_i, forward_run_in_i, powerup_run_guard_i, outside_fault_in_i, coast_stop_in_i,
          accel_stage2_select_i, alt_motor3_select_i, alt_motor2_select_i, ext_dc_brake_in_i} = line;
  always #50 clk_i = ~clk_i;
  term_model term_model_inst (.clk_i(clk_i), .want_i(want), .pol_i(pol), .reset_req_i(reset_req),
                              .line_o(line), .reset_terminal_o(reset_terminal_i));
  // short tenth and filter counts keep the run brief
  drive_input_function_sequencer #(.TENTH_CYCLES(10), .FILTER_CYCLES(4)) drive_input_function_sequencer_inst (.*);
  // one counted compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask
  // classic cycle held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= 4'hF;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    rd = wb_dat_o;
    // a missing ack is a mismatch and ends the run
    if (wb_ack_o !== 1'b1) begin
      fails++;
      finish_test();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // bounded wait for an output level; n counts cycles
  task automatic wait_on(input int p, input logic v);
    logic [3:0] s;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
      s = {resume_prev_o, alarm_o, dc_brake_o, output_on_o};
    end while (s[p] !== v && n < 200);
    if (n == 200) begin
      fails++;
      finish_test();
    end
  endtask
  // one terminal's logical level
  task automatic put(input int i, input logic v);
    @(posedge clk_i);
    want[i] <= v;
  endtask
  task automatic idle(input int c);
    repeat (c) @(negedge clk_i);
  endtask
  task automatic press_reset;
    @(posedge clk_i);
    reset_req <= 1'b1;
    @(posedge clk_i);
    reset_req <= 1'b0;
  endtask
  task automatic finish_test;
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0000_0000;
    keypad_run_i = 1'b0;
    keypad_reset_i = 1'b0;
    undervolt_i = 1'b0;
    want = 9'h0C0; // run and guard already on at power-up
    pol = 9'h000;
    reset_req = 1'b0;
    fails = 0;
    tests_run = 0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_on(ALM, 1'b1);
    chk(trip_code_o, `CODE_POWERUP);
    chk(output_on_o, 1'b0);
    press_reset();
    wait_on(ON, 1'b1);
    chk(alarm_o, 1'b0);
    // supply dip while guarded
    @(posedge clk_i) undervolt_i <= 1'b1;
    @(posedge clk_i) undervolt_i <= 1'b0;
    wait_on(ALM, 1'b1);
    chk(trip_code_o, `CODE_UNDERVOLT);
    press_reset();
    idle(30);
    chk(output_on_o, 1'b0);
    put(FWD, 1'b0);
    wait_on(ALM, 1'b0);
    put(FWD, 1'b1);
    wait_on(ON, 1'b1);
    // outside fault while running
    put(FLT, 1'b1);
    wait_on(ALM, 1'b1);
    chk(trip_code_o, `CODE_OUTSIDE);
    chk(output_on_o, 1'b0);
    put(FLT, 1'b0);
    idle(20);
    chk(alarm_o, 1'b1);
    press_reset();
    wait_on(ALM, 1'b0);
    idle(20);
    chk(output_on_o, 1'b0);
    put(FWD, 1'b0);
    idle(12);
    put(FWD, 1'b1);
    wait_on(ON, 1'b1);
    put(GRD, 1'b0);
    // brake under terminal run
    put(BRK, 1'b1);
    wait_on(DC, 1'b1);
    chk(brake_enable_o, 1'b1);
    put(BRK, 1'b0);
    wait_on(RES, 1'b1);
    chk(output_on_o, 1'b1);
    // motor set only follows when stopped
    put(SEL3, 1'b1);
    idle(20);
    chk(motor_set_o, 2'b00);
    put(FWD, 1'b0);
    wait_on(ON, 1'b0);
    idle(3);
    chk(motor_set_o, 2'b10);
    put(SET2, 1'b1);
    idle(12);
    chk(motor_set_o, 2'b01);
    put(SET2, 1'b0);
    put(SEL3, 1'b0);
    idle(12);
    chk(motor_set_o, 2'b00);
    // defaults, clamping, hole in the map
    wb(1'b0, `REG_CTRL, 32'h0);
    chk(rd, `CTRL_RST);
    wb(1'b0, `REG_RATE1, 32'h0);
    chk(rd, `RATE_RST);
    wb(1'b1, `REG_BRAKE, 32'h0000_7F3F);
    wb(1'b0, `REG_BRAKE, 32'h0);
    chk(rd, 32'h0000_6432);
    chk(brake_force_o, 7'h64);
    wb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    // second ramp pair
    wb(1'b1, `REG_RATE2, 32'h0022_0011);
    put(STG2, 1'b1);
    idle(12);
    chk(accel_time_o, 16'h0011);
    chk(decel_time_o, 16'h0022);
    wb(1'b1, `REG_CTRL, 32'h0000_0002);
    idle(2);
    chk(accel_time_o, 16'h0064);
    wb(1'b1, `REG_CTRL, 32'h0);
    put(STG2, 1'b0);
    // keypad run: coast for the delay, then brake
    wb(1'b1, `REG_BRAKE, 32'h0000_0002);
    @(posedge clk_i) keypad_run_i <= 1'b1;
    wait_on(ON, 1'b1);
    put(BRK, 1'b1);
    wait_on(ON, 1'b0);
    chk(dc_brake_o, 1'b0);
    wait_on(DC, 1'b1);
    // two tenths of ten cycles each after the output drops
    chk(n, 32'h0000_0014);
    put(BRK, 1'b0);
    idle(20);
    chk(output_on_o, 1'b0);
    @(posedge clk_i) keypad_run_i <= 1'b0;
    // coast wired normally closed, restart wait of three tenths
    @(posedge clk_i) pol[CST] <= 1'b1;
    wb(1'b1, `REG_CTRL, 32'h0000_1008);
    wb(1'b1, `REG_RESTART, 32'h0000_0003);
    idle(12);
    put(FWD, 1'b1);
    wait_on(ON, 1'b1);
    put(CST, 1'b1);
    wait_on(ON, 1'b0);
    put(CST, 1'b0);
    wait_on(ON, 1'b1);
    chk(n > 25, 1'b1);
    chk(restart_from_speed_o, 1'b1);
    finish_test();
  end
endmodule // drive_input_function_sequencer_tb
`default_nettype wire
